/* File: logic/bds_pkg.sv */
package bds_pkg;

  // ----------------------------------------------------------------------
  // Operation classes presented by the decoder for each queue slot
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_INT = 4'h0,
    OP_FP = 4'h1,
    OP_LDST = 4'h2,
    OP_LD_MULT = 4'h3,
    OP_LD_STRING = 4'h4,
    OP_ST_MULT = 4'h5,
    OP_ST_STRING = 4'h6,
    OP_WR_FIXED_EXC = 4'h7,
    OP_MOVE_EXC_CR = 4'h8,
    OP_BARRIER = 4'h9,
    OP_CTX_BARRIER = 4'hA,
    OP_WR_MSTATE = 4'hB,
    OP_INT_RETURN = 4'hC,
    OP_SYSTEM_CALL = 4'hD,
    OP_SYSREG = 4'hE,
    OP_CACHE_MGMT = 4'hF
  } bds_op_t;

  typedef enum logic [1:0] {
    UNIT_INTEGER = 2'b00,
    UNIT_FLOAT = 2'b01,
    UNIT_LOAD_STORE = 2'b10,
    UNIT_SYSREG = 2'b11
  } bds_unit_t;

  typedef enum logic [1:0] {
    REDIR_TARGET = 2'b00,
    REDIR_CORRECT = 2'b01,
    REDIR_REFETCH = 2'b10
  } bds_redir_t;

  typedef enum logic [1:0] {
    RCV_IDLE = 2'b00,
    RCV_GAP = 2'b01
  } bds_rcv_t;

  localparam int NUM_UNITS = 4;
  localparam int CQ_DEPTH_DEF = 6;
  localparam logic [NUM_UNITS-1:0] SINGLE_ISSUE_DEF = 4'hD;
  localparam int SER_COMPL = 0;
  localparam int SER_DISP = 1;
  localparam int SER_REFETCH = 2;
  localparam int REFETCH_GAP_CYC = 1;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic bds_unit_t unit_of(input bds_op_t op);
    unique case (op)
      OP_INT: unit_of = UNIT_INTEGER;
      OP_FP: unit_of = UNIT_FLOAT;
      OP_LDST, OP_LD_MULT, OP_LD_STRING, OP_ST_MULT, OP_ST_STRING,
      OP_CACHE_MGMT: unit_of = UNIT_LOAD_STORE;
      default: unit_of = UNIT_SYSREG;
    endcase
  endfunction : unit_of

  // Returns {refetch, dispatch, completion} serialization flags.
  function automatic logic [2:0] ser_of(input bds_op_t op);
    unique case (op)
      OP_INT, OP_FP, OP_LDST: ser_of = 3'h0;
      OP_ST_MULT, OP_ST_STRING, OP_SYSREG, OP_CACHE_MGMT: ser_of = 3'h1;
      OP_CTX_BARRIER: ser_of = 3'h7;
      default: ser_of = 3'h3;
    endcase
  endfunction : ser_of

endpackage : bds_pkg

/* File: logic/bds_dispatch_ctrl.sv */
// What this block does
// - Hold later instructions until a dispatch-serialized instruction retires.
// - Load multiples/strings, exception-register moves, barriers, state writes, calls dispatch-serialize.
// - Direct register multiples/strings and synchronizing instructions completion-serialize.
// - Context barrier blocks dispatch; after retiring, later instructions are refetched.
// - Dispatch up to two and retire up to two per cycle.
// - Track unit availability and stop when the needed unit cannot accept.
// - Unit unavailable if single-issue and occupied, or pipeline full.
// - On flow change reload the queue; dispatched work keeps executing.
// - Fold fetched branches out of the stream; not-taken folds request no fetch and purge nothing.
// - A taken folded branch requests its target from the cache the next cycle, unless a context-barrier refetch falls due in the same cycle.
// - A branch blocked on the condition register is predicted statically.
// - Misprediction purges queue and younger work, older work completes, refetch.
// - Link or count write then branch using it stops fetch until written.
// - When the count alone decides, ignore the condition dependency.
// - Count branch after count branch stops fetch until the first completes.
// - Conditional link branch after conditional link branch waits; unconditional one does not.
// - Second condition-dependent branch stops fetch until the first resolves.
// - A branch target modified by older instructions is waited for.
// - Only one outstanding prediction at a time.
// - Predicted-path work does not write back; full completion queue stops dispatch.
// - Misprediction flushes younger queue entries and renames, no state restore.
// - Correct-path fetch follows the flush after one clock cycle.
// - Completion-serialized work waits in its unit until older entries retire.
module bds_dispatch_ctrl #(
  parameter int CQ_DEPTH = bds_pkg::CQ_DEPTH_DEF,
  parameter logic [bds_pkg::NUM_UNITS-1:0] SINGLE_ISSUE = bds_pkg::SINGLE_ISSUE_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] iq_valid,
  input wire bds_pkg::bds_op_t iq_op0,
  input wire bds_pkg::bds_op_t iq_op1,
  output logic [1:0] disp_go,
  input wire logic [bds_pkg::NUM_UNITS-1:0] unit_occupied,
  input wire logic [bds_pkg::NUM_UNITS-1:0] unit_pipe_full,
  input wire logic [1:0] cq_retire_cnt,
  output logic [1:0] retire_limit,
  output logic writeback_block,
  output logic cser_release,
  output logic [$clog2(CQ_DEPTH+1)-1:0] cq_count,
  input wire logic br_valid,
  input wire logic br_cond,
  input wire logic br_cr_dep,
  input wire logic br_ctr_dec,
  input wire logic br_ctr_decides,
  input wire logic br_to_lr,
  input wire logic br_to_ctr,
  input wire logic br_lk,
  input wire logic br_hint,
  input wire logic br_taken,
  input wire logic br_complete,
  input wire logic lr_write_pend,
  input wire logic ctr_write_pend,
  input wire logic cr_resolve,
  input wire logic cr_taken,
  output logic br_fold,
  output logic fetch_stall,
  output logic fetch_req,
  output bds_pkg::bds_redir_t fetch_req_kind,
  output logic iq_purge,
  output logic cq_flush,
  output logic [$clog2(CQ_DEPTH+1)-1:0] cq_flush_keep,
  output logic rename_discard
);

  localparam int CW = $clog2(CQ_DEPTH + 1);

  // ----------------------------------------------------------------------
  // Availability
  // ----------------------------------------------------------------------
  function automatic logic unit_avail(input bds_pkg::bds_unit_t u,
                                      input logic [bds_pkg::NUM_UNITS-1:0] occ,
                                      input logic [bds_pkg::NUM_UNITS-1:0] full);
    unit_avail = !(full[u] || (SINGLE_ISSUE[u] && occ[u]));
  endfunction : unit_avail

  logic [CW-1:0] occ_q, occ_d;
  logic dser_hold_q, dser_hold_d;
  logic refetch_q, refetch_d;
  logic [CW-1:0] dser_pos_q, dser_pos_d;
  logic cser_wait_q, cser_wait_d;
  logic [CW-1:0] cser_pos_q, cser_pos_d;
  logic pred_pend_q, pred_pend_d;
  logic pred_dir_q, pred_dir_d;
  logic [CW-1:0] pred_cq_q, pred_cq_d;
  logic ctr_br_pend_q, ctr_br_pend_d;
  logic lk_br_pend_q, lk_br_pend_d;
  bds_pkg::bds_rcv_t rcv_q, rcv_d;
  logic fetch_req_d, iq_purge_d, cq_flush_d, rename_discard_d;
  bds_pkg::bds_redir_t fetch_req_kind_d;
  logic [CW-1:0] cq_flush_keep_d;

  bds_pkg::bds_unit_t unit0, unit1;
  logic [2:0] ser0, ser1;
  logic [CW-1:0] retired, base_pos;
  logic mispredict, blocked, cr_dep_eff, br_stall, fold_taken, dser_done;

  assign unit0 = bds_pkg::unit_of(iq_op0);
  assign unit1 = bds_pkg::unit_of(iq_op1);
  assign ser0 = bds_pkg::ser_of(iq_op0);
  assign ser1 = bds_pkg::ser_of(iq_op1);
  assign retired = CW'(cq_retire_cnt);
  assign base_pos = occ_q - retired;
  assign mispredict = cr_resolve && pred_pend_q && (cr_taken != pred_dir_q);
  assign dser_done = dser_hold_q && (retired > dser_pos_q);
  assign blocked = dser_hold_q || mispredict || (rcv_q != bds_pkg::RCV_IDLE);

  // ----------------------------------------------------------------------
  // Dispatch
  // ----------------------------------------------------------------------
  always_comb begin
    disp_go = 2'b00;
    if (iq_valid[0] && !blocked && unit_avail(unit0, unit_occupied, unit_pipe_full)
        && (int'(occ_q) < CQ_DEPTH)
        && !(ser0[bds_pkg::SER_COMPL] && cser_wait_q)) begin
      disp_go[0] = 1'b1;
    end
    // The second slot only pairs with a first slot that is not dispatch-serialized, on another unit.
    if (disp_go[0] && iq_valid[1] && !ser0[bds_pkg::SER_DISP] && !ser1[bds_pkg::SER_COMPL]
        && (unit1 != unit0) && unit_avail(unit1, unit_occupied, unit_pipe_full)
        && (int'(occ_q) + 2 <= CQ_DEPTH)) begin
      disp_go[1] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Branch folding and prediction
  // ----------------------------------------------------------------------
  always_comb begin
    cr_dep_eff = br_cond && br_cr_dep && !(br_ctr_dec && br_ctr_decides);
    br_stall = (br_to_lr && lr_write_pend) || (br_to_ctr && ctr_write_pend)
      || (br_ctr_dec && ctr_write_pend)
      || (ctr_br_pend_q && (br_ctr_dec || br_to_ctr))
      || (lk_br_pend_q && br_lk && br_cond)
      || (cr_dep_eff && pred_pend_q);
    fetch_stall = br_valid && br_stall;
    br_fold = br_valid && !br_stall && !mispredict && (rcv_q == bds_pkg::RCV_IDLE);
    fold_taken = cr_dep_eff ? br_hint : br_taken;
  end

  // ----------------------------------------------------------------------
  // Queue tracking, serialization and recovery
  // ----------------------------------------------------------------------
  always_comb begin
    occ_d = base_pos + CW'(disp_go[0]) + CW'(disp_go[1]);
    dser_hold_d = dser_hold_q;
    refetch_d = refetch_q;
    dser_pos_d = dser_pos_q - retired;
    cser_wait_d = cser_wait_q && (retired <= cser_pos_q);
    cser_pos_d = cser_pos_q - retired;
    pred_pend_d = pred_pend_q && !cr_resolve;
    pred_dir_d = pred_dir_q;
    pred_cq_d = pred_cq_q - retired;
    ctr_br_pend_d = ctr_br_pend_q && !br_complete;
    lk_br_pend_d = lk_br_pend_q && !br_complete;
    rcv_d = bds_pkg::RCV_IDLE;
    fetch_req_d = 1'b0;
    fetch_req_kind_d = bds_pkg::REDIR_TARGET;
    iq_purge_d = 1'b0;
    cq_flush_d = 1'b0;
    rename_discard_d = 1'b0;
    cq_flush_keep_d = cq_flush_keep;
    if (dser_done) begin
      dser_hold_d = 1'b0;
      refetch_d = 1'b0;
    end
    if (disp_go[0] && ser0[bds_pkg::SER_DISP]) begin
      dser_hold_d = 1'b1;
      refetch_d = ser0[bds_pkg::SER_REFETCH];
      dser_pos_d = base_pos;
    end else if (disp_go[1] && ser1[bds_pkg::SER_DISP]) begin
      dser_hold_d = 1'b1;
      refetch_d = ser1[bds_pkg::SER_REFETCH];
      dser_pos_d = base_pos + CW'(1);
    end
    if (disp_go[0] && ser0[bds_pkg::SER_COMPL]) begin
      cser_wait_d = 1'b1;
      cser_pos_d = base_pos;
    end
    if (br_fold) begin
      if (br_ctr_dec && br_cond) begin
        ctr_br_pend_d = 1'b1;
      end
      if (br_lk && br_cond) begin
        lk_br_pend_d = 1'b1;
      end
      if (cr_dep_eff) begin
        pred_pend_d = 1'b1;
        pred_dir_d = br_hint;
        pred_cq_d = occ_d;
      end
      if (fold_taken) begin
        fetch_req_d = 1'b1;
        fetch_req_kind_d = bds_pkg::REDIR_TARGET;
        iq_purge_d = 1'b1;
      end
    end
    if (dser_done && refetch_q) begin
      fetch_req_d = 1'b1;
      fetch_req_kind_d = bds_pkg::REDIR_REFETCH;
      iq_purge_d = 1'b1;
    end
    if (mispredict) begin
      occ_d = pred_cq_q - retired;
      cq_flush_keep_d = pred_cq_q - retired;
      cq_flush_d = 1'b1;
      rename_discard_d = 1'b1;
      iq_purge_d = 1'b1;
      fetch_req_d = 1'b0;
      rcv_d = bds_pkg::RCV_GAP;
      if (dser_pos_q >= pred_cq_q) begin
        dser_hold_d = 1'b0;
        refetch_d = 1'b0;
      end
      if (cser_pos_q >= pred_cq_q) begin
        cser_wait_d = 1'b0;
      end
    end
    if (rcv_q == bds_pkg::RCV_GAP) begin
      fetch_req_d = 1'b1;
      fetch_req_kind_d = bds_pkg::REDIR_CORRECT;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      occ_q <= '0;
      dser_hold_q <= 1'b0;
      refetch_q <= 1'b0;
      dser_pos_q <= '0;
      cser_wait_q <= 1'b0;
      cser_pos_q <= '0;
      pred_pend_q <= 1'b0;
      pred_dir_q <= 1'b0;
      pred_cq_q <= '0;
      ctr_br_pend_q <= 1'b0;
      lk_br_pend_q <= 1'b0;
      rcv_q <= bds_pkg::RCV_IDLE;
      fetch_req <= 1'b0;
      fetch_req_kind <= bds_pkg::REDIR_TARGET;
      iq_purge <= 1'b0;
      cq_flush <= 1'b0;
      rename_discard <= 1'b0;
      cq_flush_keep <= '0;
    end else begin
      occ_q <= occ_d;
      dser_hold_q <= dser_hold_d;
      refetch_q <= refetch_d;
      dser_pos_q <= dser_pos_d;
      cser_wait_q <= cser_wait_d;
      cser_pos_q <= cser_pos_d;
      pred_pend_q <= pred_pend_d;
      pred_dir_q <= pred_dir_d;
      pred_cq_q <= pred_cq_d;
      ctr_br_pend_q <= ctr_br_pend_d;
      lk_br_pend_q <= lk_br_pend_d;
      rcv_q <= rcv_d;
      fetch_req <= fetch_req_d;
      fetch_req_kind <= fetch_req_kind_d;
      iq_purge <= iq_purge_d;
      cq_flush <= cq_flush_d;
      rename_discard <= rename_discard_d;
      cq_flush_keep <= cq_flush_keep_d;
    end
  end

  // ----------------------------------------------------------------------
  // Completion side outputs
  // ----------------------------------------------------------------------
  always_comb begin
    cq_count = occ_q;
    writeback_block = pred_pend_q;
    cser_release = cser_wait_q && (cser_pos_q == '0);
    retire_limit = 2'h2;
    if (pred_pend_q) begin
      retire_limit = (pred_cq_q >= CW'(2)) ? 2'h2 : pred_cq_q[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_unit_avail_gate: assert property (
    disp_go[0] |-> !unit_pipe_full[unit0] && !(SINGLE_ISSUE[unit0] && unit_occupied[unit0]))
    else $error("Dispatch issued to an unavailable unit.");
  a_cq_full_stop: assert property (
    (int'(occ_q) == CQ_DEPTH) |-> disp_go == 2'b00)
    else $error("Dispatch while the completion queue is full.");
  a_dser_hold_block: assert property (
    dser_hold_q |-> disp_go == 2'b00)
    else $error("Dispatch while a serializing instruction is outstanding.");
  a_refetch_after_retire: assert property (
    (dser_done && refetch_q && !mispredict && rcv_q == bds_pkg::RCV_IDLE)
      |=> fetch_req && iq_purge && fetch_req_kind == bds_pkg::REDIR_REFETCH)
    else $error("No refetch after a refetch-serialized instruction retired.");
  a_misp_flush_gap: assert property (
    mispredict |=> (cq_flush && rename_discard && iq_purge && !fetch_req)
      ##1 (fetch_req && fetch_req_kind == bds_pkg::REDIR_CORRECT))
    else $error("Misprediction recovery sequence broken.");
  a_one_prediction: assert property (
    (pred_pend_q && br_valid && cr_dep_eff) |-> !br_fold && fetch_stall)
    else $error("Second prediction made while one is outstanding.");
  a_target_wait: assert property (
    (br_valid && ((br_to_lr && lr_write_pend) || (br_to_ctr && ctr_write_pend)))
      |-> fetch_stall && !br_fold)
    else $error("Branch folded before its target register was written.");
  a_ctr_branch_seq: assert property (
    (ctr_br_pend_q && br_valid && (br_ctr_dec || br_to_ctr)) |-> !br_fold)
    else $error("Count branch folded before the earlier one completed.");
  a_link_branch_seq: assert property (
    (lk_br_pend_q && br_valid && br_lk && br_cond) |-> !br_fold)
    else $error("Conditional link branch folded before the earlier one completed.");
  a_taken_fetch: assert property (
    (br_fold && fold_taken && !(dser_done && refetch_q))
      |=> fetch_req && fetch_req_kind == bds_pkg::REDIR_TARGET)
    else $error("Taken fold did not request its target.");
  a_pred_retire_cap: assert property (
    pred_pend_q |-> (CW'(retire_limit) <= pred_cq_q) && writeback_block)
    else $error("Retire allowed past an unresolved prediction.");

  c_dual_dispatch: cover property (disp_go == 2'b11);
  c_mispredict: cover property (mispredict ##2 fetch_req);
  c_refetch: cover property (dser_done && refetch_q);
  c_pred_correct: cover property (pred_pend_q && cr_resolve && !mispredict);

endmodule : bds_dispatch_ctrl

/* File: tb/bds_cq_model.sv */
// ----------------------------------------------------------------------
// Completion queue side: retires the oldest entries at the rate the bench
// allows, never beyond what the core permits or what the queue holds.
// ----------------------------------------------------------------------
module bds_cq_model #(
  parameter int CW = 3
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] ret_max,
  input wire logic [1:0] retire_limit,
  input wire logic [CW-1:0] cq_count,
  output logic [1:0] cq_retire_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CW-1:0] n;
  initial cq_retire_cnt = 2'h0;
  always @(negedge sys_clk) begin
    #1;
    n = reset ? '0 : CW'(ret_max);
    if (CW'(retire_limit) < n) n = CW'(retire_limit);
    if (cq_count < n) n = cq_count;
    cq_retire_cnt = n[1:0];
  end
endmodule : bds_cq_model

/* File: tb/tb_top.sv */
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 6;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] iq_valid = 2'h0;
  bds_pkg::bds_op_t iq_op0 = bds_pkg::OP_INT;
  bds_pkg::bds_op_t iq_op1 = bds_pkg::OP_INT;
  logic [3:0] unit_occupied = 4'h0;
  logic [3:0] unit_pipe_full = 4'h0;
  logic [8:0] br_bits = 9'h000;
  logic br_valid = 1'b0;
  logic br_complete = 1'b0;
  logic lr_write_pend = 1'b0;
  logic ctr_write_pend = 1'b0;
  logic cr_resolve = 1'b0;
  logic cr_taken = 1'b0;
  logic [1:0] ret_max = 2'h0;
  logic br_cond, br_cr_dep, br_ctr_dec, br_ctr_decides, br_to_lr, br_to_ctr, br_lk, br_hint;
  logic br_taken;
  logic [1:0] disp_go, cq_retire_cnt, retire_limit;
  logic writeback_block, cser_release, br_fold, fetch_stall, fetch_req;
  logic iq_purge, cq_flush, rename_discard;
  logic [2:0] cq_count, cq_flush_keep;
  bds_pkg::bds_redir_t fetch_req_kind, exp_kind;
  bds_pkg::bds_redir_t exp_q [$];
  int n_errors = 0;
  int compares = 0;
  logic [15:0] lfsr_q = 16'h004D;
  bds_pkg::bds_op_t dsr_ops [9] = '{bds_pkg::OP_LD_MULT, bds_pkg::OP_LD_STRING,
    bds_pkg::OP_WR_FIXED_EXC, bds_pkg::OP_MOVE_EXC_CR, bds_pkg::OP_BARRIER,
    bds_pkg::OP_CTX_BARRIER, bds_pkg::OP_WR_MSTATE, bds_pkg::OP_INT_RETURN,
    bds_pkg::OP_SYSTEM_CALL};
  bds_pkg::bds_op_t uops [4] = '{bds_pkg::OP_INT, bds_pkg::OP_FP, bds_pkg::OP_LDST,
    bds_pkg::OP_SYSREG};

  assign {br_cond, br_cr_dep, br_ctr_dec, br_ctr_decides, br_to_lr, br_to_ctr, br_lk, br_hint,
    br_taken} = br_bits;

  always #5 sys_clk = ~sys_clk;

  bds_dispatch_ctrl #(.CQ_DEPTH(DEPTH), .SINGLE_ISSUE(bds_pkg::SINGLE_ISSUE_DEF)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .iq_valid(iq_valid), .iq_op0(iq_op0),
    .iq_op1(iq_op1), .disp_go(disp_go), .unit_occupied(unit_occupied),
    .unit_pipe_full(unit_pipe_full), .cq_retire_cnt(cq_retire_cnt),
    .retire_limit(retire_limit), .writeback_block(writeback_block),
    .cser_release(cser_release), .cq_count(cq_count), .br_valid(br_valid),
    .br_cond(br_cond), .br_cr_dep(br_cr_dep), .br_ctr_dec(br_ctr_dec),
    .br_ctr_decides(br_ctr_decides), .br_to_lr(br_to_lr), .br_to_ctr(br_to_ctr),
    .br_lk(br_lk), .br_hint(br_hint), .br_taken(br_taken), .br_complete(br_complete),
    .lr_write_pend(lr_write_pend), .ctr_write_pend(ctr_write_pend),
    .cr_resolve(cr_resolve), .cr_taken(cr_taken), .br_fold(br_fold),
    .fetch_stall(fetch_stall), .fetch_req(fetch_req), .fetch_req_kind(fetch_req_kind),
    .iq_purge(iq_purge), .cq_flush(cq_flush), .cq_flush_keep(cq_flush_keep),
    .rename_discard(rename_discard)
  );

  bds_cq_model #(.CW(3)) cq_u (
    .sys_clk(sys_clk), .reset(reset), .ret_max(ret_max), .retire_limit(retire_limit),
    .cq_count(cq_count), .cq_retire_cnt(cq_retire_cnt)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic bds_pkg::bds_op_t pick(input logic [1:0] sel);
    case (sel)
      2'h1: return bds_pkg::OP_FP;
      2'h2: return bds_pkg::OP_LDST;
      default: return bds_pkg::OP_INT;
    endcase
  endfunction : pick

  task automatic cyc;
    @(negedge sys_clk);
  endtask : cyc

  // Leaves the queue empty and the bench at a falling edge.
  task automatic drain;
    int k;
    iq_valid = 2'h0;
    ret_max = 2'h2;
    for (k = 0; k < 30 && cq_count !== 3'h0; k++) cyc();
    cyc();
  endtask : drain

  task automatic brc(input logic [8:0] f, input logic fold);
    br_bits = f;
    br_valid = 1'b1;
    #2;
    `CHK(br_fold, fold)
    `CHK(fetch_stall, !fold)
  endtask : brc

  task automatic done_pulse;
    cyc();
    br_complete = 1'b1;
    cyc();
    br_complete = 1'b0;
  endtask : done_pulse

  task automatic end_sim;
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------------
  // Redirect monitor: every fetch redirect must match the oldest note.
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    #3;
    if (fetch_req === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(fetch_req, 1'b0)
      end else begin
        exp_kind = exp_q.pop_front();
        `CHK(fetch_req_kind, exp_kind)
        if (exp_kind != bds_pkg::REDIR_CORRECT) `CHK(iq_purge, 1'b1)
      end
    end
  end

  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    cyc();
    reset = 1'b0;
    for (int i = 0; i < 12; i++) begin
      drain();
      lfsr_q = lfsr_next(lfsr_q);
      iq_op0 = pick(lfsr_q[1:0]);
      iq_op1 = pick(lfsr_q[3:2]);
      iq_valid = 2'h3;
      #2;
      `CHK(disp_go, {iq_op0 != iq_op1, 1'b1})
    end
    for (int u = 0; u < 4; u++) begin
      drain();
      iq_op0 = uops[u];
      iq_valid = 2'h1;
      unit_pipe_full = 4'h1 << u;
      #2;
      `CHK(disp_go, 2'h0)
      cyc();
      unit_pipe_full = 4'h0;
      unit_occupied = 4'h1 << u;
      #2;
      `CHK(disp_go, {1'b0, !bds_pkg::SINGLE_ISSUE_DEF[u]})
      cyc();
      unit_occupied = 4'h0;
    end
    drain();
    ret_max = 2'h0;
    iq_op0 = bds_pkg::OP_INT;
    iq_op1 = bds_pkg::OP_FP;
    iq_valid = 2'h3;
    repeat (3) cyc();
    #2;
    `CHK(cq_count, 3'(DEPTH))
    `CHK(disp_go, 2'h0)
    for (int s = 0; s < 9; s++) begin
      drain();
      ret_max = 2'h0;
      iq_op0 = dsr_ops[s];
      iq_op1 = bds_pkg::OP_INT;
      iq_valid = 2'h3;
      #2;
      `CHK(disp_go, 2'h1)
      cyc();
      iq_op0 = bds_pkg::OP_INT;
      iq_valid = 2'h1;
      #2;
      `CHK(disp_go, 2'h0)
      cyc();
      ret_max = 2'h2;
      #2;
      `CHK(disp_go, 2'h0)
      if (dsr_ops[s] == bds_pkg::OP_CTX_BARRIER) exp_q.push_back(bds_pkg::REDIR_REFETCH);
      cyc();
      #2;
      if (dsr_ops[s] != bds_pkg::OP_CTX_BARRIER) `CHK(disp_go, 2'h1)
    end
    drain();
    ret_max = 2'h0;
    iq_op0 = bds_pkg::OP_INT;
    iq_op1 = bds_pkg::OP_ST_MULT;
    iq_valid = 2'h3;
    #2;
    `CHK(disp_go, 2'h1)
    cyc();
    iq_op0 = bds_pkg::OP_ST_MULT;
    iq_valid = 2'h1;
    #2;
    `CHK(disp_go, 2'h1)
    cyc();
    iq_valid = 2'h0;
    ret_max = 2'h1;
    #2;
    `CHK(cser_release, 1'b0)
    cyc();
    ret_max = 2'h0;
    #2;
    `CHK(cser_release, 1'b1)
    drain();
    lr_write_pend = 1'b1;
    brc(9'h010, 1'b0);
    cyc(); lr_write_pend = 1'b0; brc(9'h010, 1'b1);
    cyc(); ctr_write_pend = 1'b1; brc(9'h008, 1'b0);
    cyc(); ctr_write_pend = 1'b0; brc(9'h008, 1'b1);
    cyc(); brc(9'h140, 1'b1);
    cyc(); brc(9'h140, 1'b0);
    done_pulse(); brc(9'h140, 1'b1);
    cyc(); brc(9'h108, 1'b0);
    done_pulse(); brc(9'h108, 1'b1);
    cyc(); brc(9'h104, 1'b1);
    cyc(); brc(9'h104, 1'b0);
    done_pulse(); brc(9'h104, 1'b1);
    cyc(); exp_q.push_back(bds_pkg::REDIR_TARGET); brc(9'h005, 1'b1);
    cyc(); br_valid = 1'b0; done_pulse();
    cyc(); brc(9'h1E0, 1'b1);
    cyc(); br_valid = 1'b0; #2; `CHK(writeback_block, 1'b0)
    done_pulse(); brc(9'h180, 1'b1);
    cyc(); br_valid = 1'b0; #2; `CHK(writeback_block, 1'b1)
    cyc(); cr_resolve = 1'b1;
    cyc(); cr_resolve = 1'b0; #2; `CHK(writeback_block, 1'b0)
    `CHK(cq_flush, 1'b0)
    drain();
    ret_max = 2'h0;
    iq_valid = 2'h1;
    cyc(); iq_valid = 2'h0; exp_q.push_back(bds_pkg::REDIR_TARGET); brc(9'h182, 1'b1);
    cyc(); br_valid = 1'b0; iq_op0 = bds_pkg::OP_FP; iq_valid = 2'h1;
    #2; `CHK(writeback_block, 1'b1)
    `CHK(retire_limit, 2'h1)
    cyc(); iq_valid = 2'h0; brc(9'h180, 1'b0);
    cyc(); cr_resolve = 1'b1; exp_q.push_back(bds_pkg::REDIR_CORRECT);
    #2; `CHK(br_fold, 1'b0)
    cyc(); cr_resolve = 1'b0; br_valid = 1'b0; #2;
    `CHK(cq_flush, 1'b1)
    `CHK(rename_discard, 1'b1)
    `CHK(iq_purge, 1'b1)
    `CHK(cq_flush_keep, 3'h1)
    `CHK(fetch_req, 1'b0)
    cyc(); #2; `CHK(fetch_req, 1'b1)
    `CHK(cq_count, 3'h1)
    drain();
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule : tb_top
